// ==== tb/macroblock_ring_packet_writer_tb_top.sv ====
/*
 * Bench of the ring packet writer: one task per scenario, words judged
 * as the ring sink takes them. Assumes the package and the sink model.
 */
`timescale 1ns/1ps

module macroblock_ring_packet_writer_tb_top;
   import mbring_pkg::*;
   logic        mclk_in = 0;
   logic        rst_in = 1;
   logic        slice_start = 0;
   logic        stall = 0;
   logic        l1_used = 0;
   logic [4:0]  l0_last = '0;
   logic        wt_valid = 0;
   logic        mv_valid = 0;
   logic        coef_valid = 0;
   logic        mb_valid = 0;
   wt_req_t     wt = '0;
   mv_entry_t   mv = '0;
   coef_t       coef = '0;
   mb_desc_t    mb = '0;
   logic        wt_rdy, mv_rdy, coef_rdy, mb_rdy, ring_valid, ring_ready;
   logic [31:0] ring_data;
   int          fails = 0;
   int          checks = 0;

   always #2.5 mclk_in = ~mclk_in;

   macroblock_ring_packet_writer i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
      .slice_start_in(slice_start), .wt_valid_in(wt_valid), .wt_in(wt),
      .wt_ready_out(wt_rdy), .wt_l0_last_in(l0_last), .wt_l1_last_in(5'h0),
      .wt_l1_used_in(l1_used), .mv_valid_in(mv_valid), .mv_in(mv),
      .mv_ready_out(mv_rdy), .coef_valid_in(coef_valid), .coef_in(coef),
      .coef_ready_out(coef_rdy), .mb_valid_in(mb_valid), .mb_in(mb),
      .mb_ready_out(mb_rdy), .ring_valid_out(ring_valid),
      .ring_data_out(ring_data), .ring_ready_in(ring_ready));
   ring_sink i_sink (.mclk_in(mclk_in), .rst_in(rst_in), .stall_in(stall),
      .valid_in(ring_valid), .data_in(ring_data), .ready_out(ring_ready));

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check_word(string name, logic [31:0] exp);
      logic [31:0] got;
      got = 'x;
      repeat (300)
         if (i_sink.q.size() == 0)
            @(posedge mclk_in);
      if (i_sink.q.size() != 0)
         got = i_sink.q.pop_front();
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_sig(string name, logic exp, logic got);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // each starts one edge late so a strobe is never set twice at one edge
   task automatic put_wt(wt_req_t w);
      @(posedge mclk_in);
      wt <= w;
      wt_valid <= 1'b1;
      do @(posedge mclk_in); while (wt_rdy !== 1'b1);
      wt_valid <= 1'b0;
   endtask

   task automatic put_mv(mv_entry_t v);
      @(posedge mclk_in);
      mv <= v;
      mv_valid <= 1'b1;
      do @(posedge mclk_in); while (mv_rdy !== 1'b1);
      mv_valid <= 1'b0;
   endtask

   task automatic put_coef(coef_t c);
      @(posedge mclk_in);
      coef <= c;
      coef_valid <= 1'b1;
      do @(posedge mclk_in); while (coef_rdy !== 1'b1);
      coef_valid <= 1'b0;
   endtask

   task automatic put_mb(mb_desc_t d);
      @(posedge mclk_in);
      mb <= d;
      mb_valid <= 1'b1;
      do @(posedge mclk_in); while (mb_rdy !== 1'b1);
      mb_valid <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic test_table;
      logic [31:0] e [15] = '{32'h04000007, 32'h80, 32'h1b, 32'h0,
         32'h00031a05, 32'h1, 32'h11223344, 32'h2, 32'h0, 32'h3, 32'h0,
         32'h40, 32'h0, 32'h41, 32'h0};
      l1_used <= 1'b1;
      l0_last <= 5'h1;
      put_wt('{index:8'h01, value:32'h11223344});
      put_wt('{index:8'h80, value:32'h1b});
      put_wt('{index:8'h81, value:32'hdeadbeef});
      put_wt('{index:8'h00, value:32'h00031a05});
      @(posedge mclk_in);
      slice_start <= 1'b1;
      @(posedge mclk_in);
      slice_start <= 1'b0;
      for (int k = 0; k < 15; k++)
         check_word("table", e[k]);
      l1_used <= 1'b0;
   endtask

   task automatic test_skip;
      put_mb('{addr:13'h1234, y:8'h12, x:8'h34, first:1'b1, skip:1'b1,
         field:1'b1, default:'0});
      check_word("info hdr", 32'h00000003);
      check_word("addr", 32'h00001234);
      check_word("pos", 32'h00003412);
      check_word("flags", 32'h00000007);
      // a wrongly emitted mask would still be on its way
      repeat (8) @(posedge mclk_in);
      check_sig("no mask", 1'b1, i_sink.q.size() == 0);
   endtask

   task automatic test_intra;
      for (int b = 1; b < 4; b += 2)
         for (int p = 0; p < 16; p++)
            put_coef('{kind:BK_LUMA4, idx:4'(b), pos:6'(p), last:(p == 15),
               value:(b != 3) ? 16'h0 : (p == 2) ? 16'h0abc :
               (p == 15) ? 16'h0011 : 16'h0});
      for (int p = 1; p < 16; p++)
         put_coef('{kind:BK_CB_AC, idx:4'h0, pos:6'(p), last:(p == 15),
            value:(p == 15) ? 16'h0777 : 16'h0});
      put_mb('{addr:13'h5, y:8'h1, x:8'h2, mb_type:6'h25, intra:1'b1,
         sub_type:16'h9a5c, qp_delta:6'h2b, chroma_mode:2'h3,
         intra_modes:64'h0123456789abcdef, default:'0});
      check_word("info hdr", 32'h00000006);
      check_word("addr", 32'h5);
      check_word("pos", 32'h0201);
      check_word("flags", {7'h0, 16'h9a5c, 6'h25, 3'h0});
      check_word("qp", 32'heb);
      check_word("modes lo", 32'h89abcdef);
      check_word("modes hi", 32'h01234567);
      check_word("res hdr", 32'h0200001f);
      for (int k = 0; k < 16; k++)
         check_word("res", (k == 2) ? 32'h0abc : (k == 7) ? 32'h00110000 :
            (k == 15) ? 32'h0777 : 32'h0);
      check_word("mask hdr", 32'h03000001);
      check_word("mask", 32'h00040008);
   endtask

   task automatic test_inter;
      stall <= 1'b1;
      for (int i = 0; i < 32; i++)
         put_mv('{dy:13'(i * 3), dx:15'(i + 100), ref_idx:5'(i)});
      put_mb('{addr:13'h7, mb_type:6'h1, default:'0});
      repeat (60) @(posedge mclk_in);
      check_sig("ring valid", 1'b1, ring_valid);
      check_sig("mb ready", 1'b0, mb_rdy);
      stall <= 1'b0;
      check_word("mv hdr", 32'h01000020);
      check_word("mv ref4", 32'hffff0000);
      for (int i = 0; i < 32; i++)
         check_word("mv", {4'(i), 15'(i + 100), 13'(i * 3)});
      check_word("info hdr", 32'h00000006);
      check_word("addr", 32'h7);
      check_word("pos", 32'h0);
      check_word("flags", 32'h8);
      for (int k = 0; k < 3; k++)
         check_word("word", 32'h0);
      check_word("mask hdr", 32'h03000001);
      check_word("mask", 32'h0);
   endtask

   task automatic test_modes;
      logic [31:0] e [20] = '{32'h6, 32'h9, 32'h0, 32'h0, 32'h0, 32'h0,
         32'h0, 32'h02000003, 32'h00020001, 32'h3, 32'h03000001, 32'h0,
         32'h6, 32'ha, 32'h0, 32'h02000000, 32'h0, 32'h3210, 32'h0,
         32'h02000040};
      for (int s = 0; s < 3; s++)
         put_coef('{kind:BK_PCM, value:16'(s + 1), default:'0});
      put_mb('{addr:13'h9, intra:1'b1, pcm:1'b1, default:'0});
      for (int k = 0; k < 12; k++)
         check_word("pcm", e[k]);
      for (int p = 0; p < 64; p++)
         put_coef('{kind:BK_LUMA8, idx:4'h2, pos:6'(p), last:(p == 63),
            value:(p == 2) ? 16'h0123 : 16'h0});
      put_mb('{addr:13'ha, intra:1'b1, t8x8:1'b1,
         intra_modes:64'hfedcba9876543210, default:'0});
      for (int k = 12; k < 20; k++)
         check_word("t8x8", e[k]);
      for (int k = 0; k < 32; k++)
         check_word("res8", (k == 4) ? 32'h0123 : 32'h0);
      check_word("mask hdr", 32'h03000001);
      check_word("mask", 32'h4);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge mclk_in);
      rst_in <= 1'b0;
      test_table();
      test_skip();
      test_intra();
      test_inter();
      test_modes();
      stop_test();
   end

   // whole run needs under a thousand cycles; this is ample
   initial
   begin
      #100000;
      fails++;
      stop_test();
   end
endmodule // macroblock_ring_packet_writer_tb_top

// ==== tb/ring_sink.sv ====
/*
 * Ring sink: takes ring words into a queue, stalls on request.
 * Assumes the writer's valid/ready ring handshake on one clock.
 */
`timescale 1ns/1ps

module ring_sink
(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        stall_in,
   input  wire logic        valid_in,
   input  wire logic [31:0] data_in,
   output logic             ready_out
);
   logic [31:0] q[$];

   // ready only changes after an edge, so a word is never half taken
   always @(posedge mclk_in)
   begin
      ready_out <= !rst_in && !stall_in;
      if (valid_in && ready_out)
         q.push_back(data_in);
   end
endmodule // ring_sink

// ==== verilog/macroblock_ring_packet_writer.sv ====
/*
 * Macroblock ring packet writer with its output word FIFO.
 * Assumes the parser sends coefficients and vectors of a macroblock
 * before its descriptor, and the ring writer drains the FIFO.
 */
// What this block does
// - info header: count low, type 0 high
// - info packet always; 3 skipped, 6 otherwise
// - word0 address; word1 y then x
// - word2 flags, types, transform; word3 qp, chroma
// - words 4,5 hold sixteen intra mode nibbles
// - 8x8 intra: entries 0-3 only, rest zero
// - mb and sub types use CAVLC slice values
// - vector header count 32, type 1, ref bit4
// - vector word: dy, dx, low ref bits
// - always 32 vectors, list0 then list1
// - residual header, halfwords padded to word
// - PCM samples stored in bitstream order
// - nonzero blocks stored whole, zero blocks omitted
// - raster order, decode order, omit empty packet
// - mask packet for non-skipped, zero for PCM
// - 4x4 mask layout
// - 8x8 mask layout
// - intra 16x16 mask layout
// - mask bit set when block was stored
// - weight packet header, index/value request pairs
// - table of 0x81 entries, list1 at 0x40
// - denominators first, list0 then list1, zeros
// - 32-bit packets, type in top byte
// - slice and per-macroblock packet order
`timescale 1ns/1ps

module mbring_word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
)(
   input  wire logic             mclk_in,
   input  wire logic             rst_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic      [WIDTH-1:0] out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ff;
   logic [AW:0]      rd_ff;

   assign in_ready_out  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
   assign out_valid_out = wr_ff != rd_ff;
   assign out_data_out  = mem[rd_ff[AW-1:0]];

   always_ff @(posedge mclk_in)
   begin
      if (in_valid_in && in_ready_out)
         mem[wr_ff[AW-1:0]] <= in_data_in;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         wr_ff <= '0;
      else if (in_valid_in && in_ready_out)
         wr_ff <= wr_ff + 1'b1;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         rd_ff <= '0;
      else if (out_valid_out && out_ready_in)
         rd_ff <= rd_ff + 1'b1;
   end
endmodule // mbring_word_fifo

////////////////////////////////////////////////////////////////////////////

module macroblock_ring_packet_writer
   import mbring_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int COEF_MAX   = 384
)(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        slice_start_in,
   input  wire logic        wt_valid_in,
   input  wire wt_req_t     wt_in,
   output logic             wt_ready_out,
   input  wire logic [4:0]  wt_l0_last_in,
   input  wire logic [4:0]  wt_l1_last_in,
   input  wire logic        wt_l1_used_in,
   input  wire logic        mv_valid_in,
   input  wire mv_entry_t   mv_in,
   output logic             mv_ready_out,
   input  wire logic        coef_valid_in,
   input  wire coef_t       coef_in,
   output logic             coef_ready_out,
   input  wire logic        mb_valid_in,
   input  wire mb_desc_t    mb_in,
   output logic             mb_ready_out,
   output logic             ring_valid_out,
   output logic [31:0]      ring_data_out,
   input  wire logic        ring_ready_in
);
`include "mbring_map.svh"

   localparam int CW = $clog2(COEF_MAX + 1);
   localparam logic [3:0] ZZ4 [16] = '{4'h0, 4'h1, 4'h4, 4'h8, 4'h5,
      4'h2, 4'h3, 4'h6, 4'h9, 4'hc, 4'hd, 4'ha, 4'h7, 4'hb, 4'he, 4'hf};
   localparam logic [5:0] ZZ8 [64] = '{6'h00, 6'h01, 6'h08, 6'h10,
      6'h09, 6'h02, 6'h03, 6'h0a, 6'h11, 6'h18, 6'h20, 6'h19, 6'h12,
      6'h0b, 6'h04, 6'h05, 6'h0c, 6'h13, 6'h1a, 6'h21, 6'h28, 6'h30,
      6'h29, 6'h22, 6'h1b, 6'h14, 6'h0d, 6'h06, 6'h07, 6'h0e, 6'h15,
      6'h1c, 6'h23, 6'h2a, 6'h31, 6'h38, 6'h39, 6'h32, 6'h2b, 6'h24,
      6'h1d, 6'h16, 6'h0f, 6'h17, 6'h1e, 6'h25, 6'h2c, 6'h33, 6'h3a,
      6'h3b, 6'h34, 6'h2d, 6'h26, 6'h1f, 6'h27, 6'h2e, 6'h35, 6'h3c,
      6'h3d, 6'h36, 6'h2f, 6'h37, 6'h3e, 6'h3f};

   state_t          state_ff;
   state_t          nxt_state;
   mb_desc_t        mb_ff;
   logic [8:0]      cnt_ff;
   logic            idle;
   logic            push;
   logic            fifo_ready;
   logic            adv;
   logic [31:0]     word;
   logic            mb_take;
   logic            mb_done;
   logic            wt_done;
   logic            last_word;

   logic [15:0]     coef_mem [COEF_MAX];
   logic [CW-1:0]   base_ff;
   logic [26:0]     pres_ff;
   logic            blk_nz_ff;
   logic [CW-1:0]   off;
   logic [CW-1:0]   blk_len;
   logic [CW-1:0]   waddr;
   logic [4:0]      bit_pos;
   logic            nz_any;
   logic            coef_take;
   logic [CW-1:0]   res_words;
   logic [CW-1:0]   rd_lo;
   logic [31:0]     mask_word;

   mv_entry_t       mv_mem [32];
   logic [4:0]      mv_wr_ff;
   logic [31:0]     mv_ref4_ff;

   logic [31:0]     wt_mem [`MBR_WT_ENTRIES];
   logic [128:0]    wt_set_ff;
   logic            wt_parsed_ff;
   logic [7:0]      wt_reqs;
   logic [7:0]      wt_k;
   logic [7:0]      wt_idx;
   logic [6:0]      wt_l0_words;

   assign idle           = state_ff == ST_IDLE;
   assign push           = !idle;
   assign adv            = push && fifo_ready;
   assign coef_ready_out = idle;
   assign mv_ready_out   = idle;
   assign wt_ready_out   = idle;
   assign mb_ready_out   = idle && !(slice_start_in && wt_parsed_ff);
   assign mb_take        = mb_valid_in && mb_ready_out;
   assign coef_take      = coef_valid_in && idle;

   ////////////////////////////////////////////////////////////////////////
   // residual capture: de-zigzag into a per-macroblock halfword store

   always_comb
   begin
      off     = '0;
      blk_len = CW'(`MBR_LEN_CDC);
      bit_pos = 5'h00;
      case (coef_in.kind)
         BK_LUMA4, BK_LUMA8, BK_LUMA_DC:
         begin
            off     = CW'(ZZ4[coef_in.pos[3:0]]);
            blk_len = CW'(`MBR_LEN_4X4);
            bit_pos = {1'b0, coef_in.idx};
            if (coef_in.kind == BK_LUMA8)
            begin
               off     = CW'(ZZ8[coef_in.pos]);
               blk_len = CW'(`MBR_LEN_8X8);
            end
            if (coef_in.kind == BK_LUMA_DC)
               bit_pos = 5'h10;
         end
         BK_LUMA_AC, BK_CB_AC, BK_CR_AC:
         begin
            // dc position is not stored, so raster 1 lands at 0
            off     = CW'(ZZ4[coef_in.pos[3:0]]) - CW'(1);
            blk_len = CW'(`MBR_LEN_AC);
            bit_pos = {1'b0, coef_in.idx};
            if (coef_in.kind == BK_CB_AC)
               bit_pos = 5'h13 + {3'h0, coef_in.idx[1:0]};
            if (coef_in.kind == BK_CR_AC)
               bit_pos = 5'h17 + {3'h0, coef_in.idx[1:0]};
         end
         BK_CB_DC: bit_pos = 5'h11;
         BK_CR_DC: bit_pos = 5'h12;
         BK_PCM:   off     = '0;
         default:  off     = CW'(coef_in.pos);
      endcase
      if (coef_in.kind == BK_CB_DC || coef_in.kind == BK_CR_DC)
         off = CW'(coef_in.pos[1:0]);
   end

   assign waddr  = base_ff + off;
   assign nz_any = blk_nz_ff || (coef_in.value != 16'h0000);

   always_ff @(posedge mclk_in)
   begin
      if (coef_take && waddr < CW'(COEF_MAX))
         coef_mem[waddr] <= coef_in.value;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in || mb_done)
      begin
         base_ff   <= '0;
         pres_ff   <= '0;
         blk_nz_ff <= 1'b0;
      end
      else if (coef_take)
      begin
         if (coef_in.kind == BK_PCM)
            base_ff <= base_ff + CW'(1);
         else if (coef_in.last)
         begin
            blk_nz_ff <= 1'b0;
            if (nz_any)
            begin
               base_ff          <= base_ff + blk_len;
               pres_ff[bit_pos] <= 1'b1;
            end
         end
         else
            blk_nz_ff <= nz_any;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // vector and weight table capture

   always_ff @(posedge mclk_in)
   begin
      if (mv_valid_in && idle)
         mv_mem[mv_wr_ff] <= mv_in;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in || mb_done)
         mv_wr_ff <= 5'h00;
      else if (mv_valid_in && idle)
      begin
         mv_wr_ff             <= mv_wr_ff + 5'h01;
         mv_ref4_ff[mv_wr_ff] <= mv_in.ref_idx[4];
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (wt_valid_in && idle && wt_in.index <= `MBR_WT_DENOM_IDX)
         wt_mem[wt_in.index] <= wt_in.value;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in || wt_done)
      begin
         wt_set_ff    <= '0;
         wt_parsed_ff <= 1'b0;
      end
      else if (wt_valid_in && idle && wt_in.index <= `MBR_WT_DENOM_IDX)
      begin
         wt_set_ff[wt_in.index] <= 1'b1;
         wt_parsed_ff           <= 1'b1;
      end
   end

   // counts follow the live ref inputs; they must hold during emission
   assign wt_l0_words = {1'b0, wt_l0_last_in, 1'b0} + 7'h02;
   assign wt_reqs     = 8'h01 + {1'b0, wt_l0_words} + (wt_l1_used_in ?
                        {2'h0, wt_l1_last_in, 1'b0} + 8'h02 : 8'h00);
   assign wt_k        = cnt_ff[8:1];

   always_comb
   begin
      if (wt_k == 8'h00)
         wt_idx = `MBR_WT_DENOM_IDX;
      else if (wt_k - 8'h01 < {1'b0, wt_l0_words})
         wt_idx = wt_k - 8'h01;
      else
         wt_idx = `MBR_WT_L1_BASE + wt_k - 8'h01 - {1'b0, wt_l0_words};
   end

   ////////////////////////////////////////////////////////////////////////
   // emitter

   assign res_words = (base_ff + CW'(1)) >> 1;
   assign rd_lo     = CW'({cnt_ff, 1'b0});

   always_comb
   begin
      if (mb_ff.pcm)
         mask_word = 32'h0;
      else if (mb_ff.i16)
         mask_word = {5'h0, pres_ff[26:17], pres_ff[15:0],
                      pres_ff[16]};
      else if (mb_ff.t8x8)
         mask_word = {18'h0, pres_ff[26:17], pres_ff[3:0]};
      else
         mask_word = {6'h0, pres_ff[26:17], pres_ff[15:0]};
   end

   always_comb
   begin
      word = 32'h0;
      case (state_ff)
         ST_WT_HDR:   word = {`MBR_TYPE_WT, 16'h0, wt_reqs};
         ST_WT_W:
            if (!cnt_ff[0])
               word = {24'h0, wt_idx};
            else if (wt_set_ff[wt_idx])
               word = wt_mem[wt_idx];
         ST_MV_HDR0:  word = {`MBR_TYPE_MV, `MBR_MV_CNT};
         ST_MV_HDR1:  word = mv_ref4_ff;
         ST_MV_W:
            word = {mv_mem[cnt_ff[4:0]].ref_idx[3:0],
                    mv_mem[cnt_ff[4:0]].dx,
                    mv_mem[cnt_ff[4:0]].dy};
         ST_INFO_HDR:
            word = {`MBR_TYPE_INFO, mb_ff.skip ? `MBR_INFO_SKIP_CNT
                                               : `MBR_INFO_FULL_CNT};
         ST_INFO_W:
            case (cnt_ff[2:0])
               3'h0: word = {19'h0, mb_ff.addr};
               3'h1: word = {16'h0, mb_ff.x, mb_ff.y};
               3'h2: word = {6'h0, mb_ff.t8x8, mb_ff.sub_type,
                             mb_ff.mb_type, mb_ff.field, mb_ff.skip,
                             mb_ff.first};
               3'h3: word = {24'h0, mb_ff.chroma_mode,
                             mb_ff.qp_delta};
               3'h4:
                  if (mb_ff.intra && mb_ff.t8x8)
                     word = {16'h0, mb_ff.intra_modes[15:0]};
                  else
                     word = mb_ff.intra_modes[31:0];
               3'h5:
                  if (!(mb_ff.intra && mb_ff.t8x8))
                     word = mb_ff.intra_modes[63:32];
               default: word = 32'h0;
            endcase
         ST_RES_HDR:
            word = {`MBR_TYPE_RES, 24'(base_ff)};
         ST_RES_W:
            word = {(rd_lo + CW'(1) < base_ff) ?
                    coef_mem[rd_lo + CW'(1)] : 16'h0,
                    coef_mem[rd_lo]};
         ST_MASK_HDR: word = {`MBR_TYPE_MASK, `MBR_MASK_CNT};
         ST_MASK_W:   word = mask_word;
         default:     word = 32'h0;
      endcase
   end

   always_comb
   begin
      case (state_ff)
         ST_WT_W:   last_word = cnt_ff == {wt_reqs, 1'b0} - 9'h001;
         ST_MV_W:   last_word = cnt_ff == `MBR_MV_LAST_WORD;
         ST_INFO_W: last_word = cnt_ff == (mb_ff.skip ? 9'h002 : 9'h005);
         ST_RES_W:  last_word = cnt_ff == 9'(res_words - CW'(1));
         default:   last_word = 1'b1;
      endcase
   end

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
            if (slice_start_in && wt_parsed_ff)
               nxt_state = ST_WT_HDR;
            else if (mb_take)
               nxt_state = (!mb_in.skip && !mb_in.intra) ?
                           ST_MV_HDR0 : ST_INFO_HDR;
         ST_WT_HDR:   if (adv) nxt_state = ST_WT_W;
         ST_WT_W:     if (adv && last_word) nxt_state = ST_IDLE;
         ST_MV_HDR0:  if (adv) nxt_state = ST_MV_HDR1;
         ST_MV_HDR1:  if (adv) nxt_state = ST_MV_W;
         ST_MV_W:     if (adv && last_word) nxt_state = ST_INFO_HDR;
         ST_INFO_HDR: if (adv) nxt_state = ST_INFO_W;
         ST_INFO_W:
            if (adv && last_word)
            begin
               if (base_ff != '0)
                  nxt_state = ST_RES_HDR;
               else if (!mb_ff.skip)
                  nxt_state = ST_MASK_HDR;
               else
                  nxt_state = ST_IDLE;
            end
         ST_RES_HDR:  if (adv) nxt_state = ST_RES_W;
         ST_RES_W:    if (adv && last_word) nxt_state = ST_MASK_HDR;
         ST_MASK_HDR: if (adv) nxt_state = ST_MASK_W;
         ST_MASK_W:   if (adv) nxt_state = ST_IDLE;
         default:     nxt_state = ST_IDLE;
      endcase
   end

   assign mb_done = adv && nxt_state == ST_IDLE && state_ff != ST_WT_W;
   assign wt_done = adv && nxt_state == ST_IDLE && state_ff == ST_WT_W;

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in || idle)
         cnt_ff <= 9'h000;
      else if (adv)
         cnt_ff <= (nxt_state != state_ff) ? 9'h000 : cnt_ff + 9'h001;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         mb_ff <= '0;
      else if (mb_take)
         mb_ff <= mb_in;
   end

   // stalls the emitter, and through it every capture port, when full
   mbring_word_fifo #(
      .WIDTH (32),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk_in       (mclk_in),
      .rst_in        (rst_in),
      .in_valid_in   (push),
      .in_data_in    (word),
      .in_ready_out  (fifo_ready),
      .out_valid_out (ring_valid_out),
      .out_data_out  (ring_data_out),
      .out_ready_in  (ring_ready_in)
   );

   ////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   a_info_header: assert property (adv && state_ff == ST_INFO_HDR |->
      word == (mb_ff.skip ? 32'h00000003 : 32'h00000006))
      else $error("info header wrong");
   a_mv_header: assert property (adv && state_ff == ST_MV_HDR0 |=>
      state_ff == ST_MV_HDR1 && $past(word) == 32'h01000020)
      else $error("vector header wrong");
   a_mv_count: assert property (adv && state_ff == ST_MV_W &&
      cnt_ff == 9'h01f |=> state_ff == ST_INFO_HDR)
      else $error("vector count wrong");
   a_res_pad: assert property (adv && state_ff == ST_RES_W &&
      rd_lo + CW'(1) == base_ff |-> word[31:16] == 16'h0)
      else $error("padding not zero");
   a_res_omit: assert property (adv && state_ff == ST_INFO_W &&
      last_word && base_ff == '0 && !mb_ff.skip |=>
      state_ff == ST_MASK_HDR)
      else $error("empty residual emitted");
   a_mask_pcm: assert property (adv && state_ff == ST_MASK_W &&
      mb_ff.pcm |-> word == 32'h0)
      else $error("pcm mask not zero");
   a_skip_order: assert property (mb_take && mb_in.skip |=>
      state_ff == ST_INFO_HDR)
      else $error("skipped macroblock order wrong");
   a_wt_first: assert property (adv && state_ff == ST_WT_W &&
      cnt_ff == 9'h000 |-> word == 32'h00000080)
      else $error("denominator entry not first");
   a_type_byte: assert property (adv && (state_ff == ST_INFO_HDR ||
      state_ff == ST_RES_HDR) |-> word[31:24] <= `MBR_TYPE_LAST)
      else $error("bad packet type");

   c_skip_mb: cover property (mb_take && mb_in.skip ##1 !idle[*4] ##1 idle);
   c_inter_mb: cover property (state_ff == ST_MV_W ##1
      state_ff == ST_INFO_HDR);
   c_res_mb: cover property (state_ff == ST_RES_W ##1
      state_ff == ST_MASK_HDR);
   c_wt_tbl: cover property (wt_done);
endmodule // macroblock_ring_packet_writer

// ==== verilog/mbring_map.svh ====
/*
 * Constant map of the macroblock ring packet writer: packet type codes,
 * fixed header counts, weight table indices and block lengths.
 * Assumes it is included by bare name once per compilation unit.
 */
`ifndef MBRING_MAP_SVH
`define MBRING_MAP_SVH

`define MBR_TYPE_INFO     8'h00
`define MBR_TYPE_MV       8'h01
`define MBR_TYPE_RES      8'h02
`define MBR_TYPE_MASK     8'h03
`define MBR_TYPE_WT       8'h04
`define MBR_TYPE_LAST     8'h04
`define MBR_INFO_SKIP_CNT 24'h000003
`define MBR_INFO_FULL_CNT 24'h000006
`define MBR_MV_CNT        24'h000020
`define MBR_MASK_CNT      24'h000001
`define MBR_MV_LAST_WORD  9'h01f
`define MBR_WT_DENOM_IDX  8'h80
`define MBR_WT_L1_BASE    8'h40
`define MBR_WT_ENTRIES    129
`define MBR_LEN_4X4       16
`define MBR_LEN_8X8       64
`define MBR_LEN_AC        15
`define MBR_LEN_CDC       4

`endif

// ==== verilog/mbring_pkg.sv ====
/*
 * Types of the macroblock ring packet writer: emitter states, block kinds
 * and the records that the parser hands over.
 * Assumes nothing of its surroundings.
 */
package mbring_pkg;

   typedef enum logic [3:0]
   {
      ST_IDLE     = 4'h0,
      ST_WT_HDR   = 4'h1,
      ST_WT_W     = 4'h2,
      ST_MV_HDR0  = 4'h3,
      ST_MV_HDR1  = 4'h4,
      ST_MV_W     = 4'h5,
      ST_INFO_HDR = 4'h6,
      ST_INFO_W   = 4'h7,
      ST_RES_HDR  = 4'h8,
      ST_RES_W    = 4'h9,
      ST_MASK_HDR = 4'ha,
      ST_MASK_W   = 4'hb
   } state_t;

   typedef enum logic [3:0]
   {
      BK_LUMA4   = 4'h0,
      BK_LUMA8   = 4'h1,
      BK_LUMA_DC = 4'h2,
      BK_LUMA_AC = 4'h3,
      BK_CB_DC   = 4'h4,
      BK_CR_DC   = 4'h5,
      BK_CB_AC   = 4'h6,
      BK_CR_AC   = 4'h7,
      BK_PCM     = 4'h8
   } blk_kind_t;

   typedef struct packed {
      blk_kind_t   kind;
      logic [3:0]  idx;
      logic [5:0]  pos;
      logic [15:0] value;
      logic        last;
   } coef_t;

   typedef struct packed {
      logic [12:0] dy;
      logic [14:0] dx;
      logic [4:0]  ref_idx;
   } mv_entry_t;

   typedef struct packed {
      logic [7:0]  index;
      logic [31:0] value;
   } wt_req_t;

   typedef struct packed {
      logic [12:0] addr;
      logic [7:0]  y;
      logic [7:0]  x;
      logic        first;
      logic        skip;
      logic        field;
      logic [5:0]  mb_type;
      logic [15:0] sub_type;
      logic        t8x8;
      logic [5:0]  qp_delta;
      logic [1:0]  chroma_mode;
      logic [63:0] intra_modes;
      logic        intra;
      logic        pcm;
      logic        i16;
   } mb_desc_t;

endpackage
